/* pscr_consts.vh */
// register map, field layout and reset values of the indexed control block
`ifndef PSCR_CONSTS_VH
`define PSCR_CONSTS_VH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define PSCR_IDX_CLK_LOW 8'h54
`define PSCR_IDX_RB_LOW 8'h62
`define PSCR_IDX_RB_HIGH 8'h63
`define PSCR_IDX_MASK 8'h64
`define PSCR_IDX_PAL_DATA 8'h65
`define PSCR_IDX_SEQ 8'h66
`define PSCR_IDX_RED_HOLD 8'h67
`define PSCR_IDX_GRN_HOLD 8'h68
`define PSCR_IDX_BLU_HOLD 8'h69
`define PSCR_IDX_SPR_DATA 8'h6A
`define PSCR_IDX_SPR_HOLD 8'h6B
`define PSCR_IDX_CLK_HIGH 8'h70

// ****************************************************************
// field positions
// ****************************************************************
`define PSCR_SEQ_ORDER_BIT 2
`define PSCR_SEQ_ELEM_HI 1
`define PSCR_SEQ_ELEM_LO 0
`define PSCR_CLK_SEL_HI 3
`define PSCR_CLK_SEL_LO 2
`define PSCR_CLK_DIV_HI 1
`define PSCR_CLK_DIV_LO 0
`define PSCR_CLK_HIGH_BIT 7
`define PSCR_PAL_KEEP_HI 7
`define PSCR_PAL_KEEP_LO 2
`define PSCR_SPR_HIGH_BITS 6

// ****************************************************************
// colour elements, clock codes and reset values
// ****************************************************************
`define PSCR_EL_RED 2'h0
`define PSCR_EL_GRN 2'h1
`define PSCR_EL_BLU 2'h2
`define PSCR_EL_UNUSED 2'h3
`define PSCR_SEL_STD 2'h0
`define PSCR_SEL_TEXT9 2'h1
`define PSCR_SEL_EXT 2'h2
`define PSCR_SEL_HIRES 2'h3
`define PSCR_DIV_ONE 2'h0
`define PSCR_DIV_TWO 2'h1
`define PSCR_RST_BYTE 8'h00
`define PSCR_RST_IDX 14'h0000
`define PSCR_IDX_ONE 14'h0001
`define PSCR_PAD2 2'h0
`define PSCR_RST_WORD 32'h00000000
`define PSCR_RST_RGB 18'h00000
`define PSCR_SRC_NONE 5'h00
`define PSCR_SRC_STD 5'h01
`define PSCR_SRC_TEXT9 5'h02
`define PSCR_SRC_EXT 5'h04
`define PSCR_SRC_HIRES 5'h08
`define PSCR_SRC_WIDE 5'h10

`endif

/* pscr_regs.v */
// indexed palette, sprite and video clock select register bank on apb
`timescale 1ns/1ns
`default_nettype none
`include "pscr_consts.vh"

module pscr_regs (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // write index block (index 60/61 lives outside)
  input wire [7:0] pal_wr_index,
  input wire [13:0] spr_wr_index,
  output reg pal_wr_advance,
  output reg spr_wr_advance,
  // display pixel path
  input wire [7:0] pixel_value,
  output reg [7:0] lookup_index,
  output reg [17:0] lookup_rgb,
  input wire [13:0] spr_disp_addr,
  output reg [7:0] spr_disp_byte,
  // video clock control
  output reg [4:0] clock_source,
  output reg clock_sel_reserved,
  output reg clock_div_two,
  output reg clock_div_reserved
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [5:0] red_mem_ff [0:255];
  reg [5:0] grn_mem_ff [0:255];
  reg [5:0] blu_mem_ff [0:255];
  reg [7:0] spr_mem_ff [0:16383];

  reg [13:0] rb_index_ff;
  reg [7:0] mask_ff;
  reg colour_order_ff;
  reg [1:0] current_colour_element_ff;
  reg [7:0] red_hold_ff;
  reg [7:0] grn_hold_ff;
  reg [7:0] blu_hold_ff;
  reg [7:0] spr_hold_ff;
  reg [1:0] clock_select_low_ff;
  reg [1:0] video_clock_divide_ff;
  reg clock_select_high_bit_ff;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire [7:0] idx = paddr[9:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  reg mapped;

  always @* begin
    case (idx)
      `PSCR_IDX_CLK_LOW, `PSCR_IDX_RB_LOW, `PSCR_IDX_RB_HIGH,
      `PSCR_IDX_MASK, `PSCR_IDX_PAL_DATA, `PSCR_IDX_SEQ,
      `PSCR_IDX_RED_HOLD, `PSCR_IDX_GRN_HOLD, `PSCR_IDX_BLU_HOLD,
      `PSCR_IDX_SPR_DATA, `PSCR_IDX_SPR_HOLD,
      `PSCR_IDX_CLK_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states; read data was latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  wire done = access & mapped;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  wire [7:0] wbyte = pwdata[7:0];

  // ****************************************************************
  // colour element sequencing
  // ****************************************************************
  // element currently reached by the palette data port
  reg [7:0] elem_hold;
  always @* begin
    case (current_colour_element_ff)
      `PSCR_EL_RED: elem_hold = red_hold_ff;
      `PSCR_EL_GRN: elem_hold = grn_hold_ff;
      `PSCR_EL_BLU: elem_hold = blu_hold_ff;
      default: elem_hold = `PSCR_RST_BYTE;
    endcase
  end

  reg [1:0] nxt_elem;
  reg elem_wrap;
  always @* begin
    nxt_elem = `PSCR_EL_RED;
    elem_wrap = 1'b1;
    if (!colour_order_ff) begin
      case (current_colour_element_ff)
        `PSCR_EL_RED: begin
          nxt_elem = `PSCR_EL_GRN;
          elem_wrap = 1'b0;
        end
        `PSCR_EL_GRN: begin
          nxt_elem = `PSCR_EL_BLU;
          elem_wrap = 1'b0;
        end
        default: begin
          nxt_elem = `PSCR_EL_RED;
          elem_wrap = 1'b1;
        end
      endcase
    end else begin
      case (current_colour_element_ff)
        `PSCR_EL_RED: begin
          nxt_elem = `PSCR_EL_BLU;
          elem_wrap = 1'b0;
        end
        `PSCR_EL_BLU: begin
          nxt_elem = `PSCR_EL_GRN;
          elem_wrap = 1'b0;
        end
        `PSCR_EL_GRN: begin
          nxt_elem = `PSCR_EL_UNUSED;
          elem_wrap = 1'b0;
        end
        default: begin
          nxt_elem = `PSCR_EL_RED;
          elem_wrap = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // prefetch source selection
  // ****************************************************************
  wire wr_rb_low = wr & (idx == `PSCR_IDX_RB_LOW);
  wire wr_rb_high = wr & (idx == `PSCR_IDX_RB_HIGH);
  wire rd_pal = rd & (idx == `PSCR_IDX_PAL_DATA);
  wire wr_pal = wr & (idx == `PSCR_IDX_PAL_DATA);
  wire rd_spr = rd & (idx == `PSCR_IDX_SPR_DATA);
  wire wr_spr = wr & (idx == `PSCR_IDX_SPR_DATA);
  wire pal_refetch = rd_pal & elem_wrap;

  // index that the fetch uses: the value being written, or the stored one
  reg [13:0] fetch_idx;
  always @* begin
    if (wr_rb_low) begin
      fetch_idx = {rb_index_ff[13:8], wbyte};
    end else if (wr_rb_high) begin
      fetch_idx = {wbyte[`PSCR_SPR_HIGH_BITS-1:0], rb_index_ff[7:0]};
    end else begin
      fetch_idx = rb_index_ff;
    end
  end

  // the upper index bits never reach the palette, so 256 entries wrap
  wire [7:0] pal_fetch_idx = fetch_idx[7:0];

  // ****************************************************************
  // register updates
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_index_ff <= `PSCR_RST_IDX;
      mask_ff <= `PSCR_RST_BYTE;
      colour_order_ff <= 1'b0;
      current_colour_element_ff <= `PSCR_EL_RED;
      red_hold_ff <= `PSCR_RST_BYTE;
      grn_hold_ff <= `PSCR_RST_BYTE;
      blu_hold_ff <= `PSCR_RST_BYTE;
      spr_hold_ff <= `PSCR_RST_BYTE;
      clock_select_low_ff <= `PSCR_SEL_STD;
      video_clock_divide_ff <= `PSCR_DIV_ONE;
      clock_select_high_bit_ff <= 1'b0;
      pal_wr_advance <= 1'b0;
      spr_wr_advance <= 1'b0;
    end else begin
      pal_wr_advance <= wr_pal & elem_wrap;
      spr_wr_advance <= wr_spr;
      // index writes fetch first, then step the 14-bit index as one value
      if (wr_rb_low | wr_rb_high) begin
        rb_index_ff <= fetch_idx + `PSCR_IDX_ONE;
        spr_hold_ff <= spr_mem_ff[fetch_idx];
      end
      if (wr_rb_low | pal_refetch) begin
        red_hold_ff <= {red_mem_ff[pal_fetch_idx], `PSCR_PAD2};
        grn_hold_ff <= {grn_mem_ff[pal_fetch_idx], `PSCR_PAD2};
        blu_hold_ff <= {blu_mem_ff[pal_fetch_idx], `PSCR_PAD2};
      end
      if (pal_refetch) begin
        rb_index_ff <= rb_index_ff + `PSCR_IDX_ONE;
      end
      // a sprite data read hands out the holding byte and reloads it
      if (rd_spr) begin
        spr_hold_ff <= spr_mem_ff[rb_index_ff];
        rb_index_ff <= rb_index_ff + `PSCR_IDX_ONE;
      end
      if (rd_pal | wr_pal) begin
        current_colour_element_ff <= nxt_elem;
      end
      if (wr) begin
        case (idx)
          `PSCR_IDX_MASK: mask_ff <= wbyte;
          `PSCR_IDX_SEQ: begin
            colour_order_ff <= wbyte[`PSCR_SEQ_ORDER_BIT];
            current_colour_element_ff <=
              wbyte[`PSCR_SEQ_ELEM_HI:`PSCR_SEQ_ELEM_LO];
          end
          `PSCR_IDX_RED_HOLD: red_hold_ff <= wbyte;
          `PSCR_IDX_GRN_HOLD: grn_hold_ff <= wbyte;
          `PSCR_IDX_BLU_HOLD: blu_hold_ff <= wbyte;
          `PSCR_IDX_SPR_HOLD: spr_hold_ff <= wbyte;
          `PSCR_IDX_CLK_LOW: begin
            // upper nibble is written-zero and not kept
            clock_select_low_ff <=
              wbyte[`PSCR_CLK_SEL_HI:`PSCR_CLK_SEL_LO];
            video_clock_divide_ff <=
              wbyte[`PSCR_CLK_DIV_HI:`PSCR_CLK_DIV_LO];
          end
          `PSCR_IDX_CLK_HIGH: begin
            clock_select_high_bit_ff <= wbyte[`PSCR_CLK_HIGH_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // palette and sprite memories (no reset on arrays)
  // ****************************************************************
  always @(posedge pclk) begin
    if (wr_pal) begin
      // low two bits of the byte are dropped
      case (current_colour_element_ff)
        `PSCR_EL_RED: red_mem_ff[pal_wr_index] <=
          wbyte[`PSCR_PAL_KEEP_HI:`PSCR_PAL_KEEP_LO];
        `PSCR_EL_GRN: grn_mem_ff[pal_wr_index] <=
          wbyte[`PSCR_PAL_KEEP_HI:`PSCR_PAL_KEEP_LO];
        `PSCR_EL_BLU: blu_mem_ff[pal_wr_index] <=
          wbyte[`PSCR_PAL_KEEP_HI:`PSCR_PAL_KEEP_LO];
        default: begin
        end
      endcase
    end
    // bytes are stored as written; first packed pixel sits in the low bits
    if (wr_spr) begin
      spr_mem_ff[spr_wr_index] <= wbyte;
    end
  end

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  reg [7:0] rbyte;
  always @* begin
    case (idx)
      `PSCR_IDX_CLK_LOW: rbyte = {4'h0, clock_select_low_ff,
                                  video_clock_divide_ff};
      `PSCR_IDX_RB_LOW: rbyte = rb_index_ff[7:0];
      `PSCR_IDX_RB_HIGH: rbyte = {`PSCR_PAD2, rb_index_ff[13:8]};
      `PSCR_IDX_MASK: rbyte = mask_ff;
      `PSCR_IDX_PAL_DATA: rbyte = elem_hold;
      `PSCR_IDX_SEQ: rbyte = {5'h00, colour_order_ff,
                              current_colour_element_ff};
      `PSCR_IDX_RED_HOLD: rbyte = red_hold_ff;
      `PSCR_IDX_GRN_HOLD: rbyte = grn_hold_ff;
      `PSCR_IDX_BLU_HOLD: rbyte = blu_hold_ff;
      `PSCR_IDX_SPR_DATA: rbyte = spr_hold_ff;
      `PSCR_IDX_SPR_HOLD: rbyte = spr_hold_ff;
      `PSCR_IDX_CLK_HIGH: rbyte = {clock_select_high_bit_ff, 7'h00};
      default: rbyte = `PSCR_RST_BYTE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PSCR_RST_WORD;
    end else if (setup) begin
      prdata <= {24'h000000, rbyte};
    end
  end

  // ****************************************************************
  // display path and clock select decode
  // ****************************************************************
  // pixel_value is same-domain logic from the serializer
  wire [7:0] masked = pixel_value & mask_ff;
  reg [4:0] nxt_source;
  reg nxt_reserved;

  always @* begin
    nxt_source = `PSCR_SRC_NONE;
    nxt_reserved = 1'b0;
    if (!clock_select_high_bit_ff) begin
      case (clock_select_low_ff)
        `PSCR_SEL_STD: nxt_source = `PSCR_SRC_STD;
        `PSCR_SEL_TEXT9: nxt_source = `PSCR_SRC_TEXT9;
        `PSCR_SEL_EXT: nxt_source = `PSCR_SRC_EXT;
        default: nxt_source = `PSCR_SRC_HIRES;
      endcase
    end else if (clock_select_low_ff == `PSCR_SEL_STD) begin
      nxt_source = `PSCR_SRC_WIDE;
    end else begin
      nxt_reserved = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookup_index <= `PSCR_RST_BYTE;
      lookup_rgb <= `PSCR_RST_RGB;
      spr_disp_byte <= `PSCR_RST_BYTE;
      clock_source <= `PSCR_SRC_STD;
      clock_sel_reserved <= 1'b0;
      clock_div_two <= 1'b0;
      clock_div_reserved <= 1'b0;
    end else begin
      lookup_index <= masked;
      lookup_rgb <= {red_mem_ff[masked], grn_mem_ff[masked],
                     blu_mem_ff[masked]};
      spr_disp_byte <= spr_mem_ff[spr_disp_addr];
      clock_source <= nxt_source;
      clock_sel_reserved <= nxt_reserved;
      clock_div_two <= (video_clock_divide_ff == `PSCR_DIV_TWO);
      clock_div_reserved <= video_clock_divide_ff[1];
    end
  end

endmodule
`default_nettype wire

/* pscr_regs_sva.sv */
// assertion checker for the palette, sprite and clock register bank
`timescale 1ns/1ns
`default_nettype none
`include "pscr_consts.vh"
module pscr_regs_sva (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // write index block
  input wire logic [7:0] pal_wr_index,
  input wire logic [13:0] spr_wr_index,
  input wire logic pal_wr_advance,
  input wire logic spr_wr_advance,
  // pixel path
  input wire logic [7:0] pixel_value,
  input wire logic [7:0] lookup_index,
  input wire logic [17:0] lookup_rgb,
  input wire logic [13:0] spr_disp_addr,
  input wire logic [7:0] spr_disp_byte,
  // clock control
  input wire logic [4:0] clock_source,
  input wire logic clock_sel_reserved,
  input wire logic clock_div_two,
  input wire logic clock_div_reserved
);
  // ****************************************************************
  // shadow copies of the mask and low clock registers that drive outputs
  // ****************************************************************
  wire wr_acc = psel && penable && pwrite;
  wire spr_wr = wr_acc && paddr[9:2] == `PSCR_IDX_SPR_DATA;
  wire pal_wr = wr_acc && paddr[9:2] == `PSCR_IDX_PAL_DATA;
  logic [7:0] mask_sh;
  logic [7:0] clk_sh;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sh <= 8'h00;
      clk_sh <= 8'h00;
    end else if (wr_acc && paddr[9:2] == `PSCR_IDX_MASK) begin
      mask_sh <= pwdata[7:0];
    end else if (wr_acc && paddr[9:2] == `PSCR_IDX_CLK_LOW) begin
      clk_sh <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // properties
  // ****************************************************************
  AST_MASK: assert property (1'b1 |=>
    lookup_index == ($past(pixel_value) & $past(mask_sh)))
    else $error("lookup index is not pixel and mask");
  AST_ERR_ACC: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  AST_UPPER: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_ONEHOT: assert property ($onehot0(clock_source))
    else $error("clock source not one-hot");
  AST_RSV: assert property (clock_sel_reserved |-> clock_source == 5'h00)
    else $error("reserved clock still selects a source");
  AST_DIV: assert property ($stable(clk_sh) [*2] |->
    clock_div_two == (clk_sh[1:0] == `PSCR_DIV_TWO)
    && clock_div_reserved == clk_sh[1])
    else $error("divide outputs disagree with divide field");
  AST_SPR_ADV: assert property (spr_wr |=> spr_wr_advance)
    else $error("sprite write did not advance");
  AST_SPR_ONLY: assert property (spr_wr_advance |-> $past(spr_wr))
    else $error("sprite advance without write");
  AST_PAL_ADV: assert property (pal_wr_advance |-> $past(pal_wr))
    else $error("palette advance without write");
  AST_PAL_PULSE: assert property (pal_wr_advance |=> !pal_wr_advance)
    else $error("palette advance longer than a pulse");
  COV_PAL: cover property (pal_wr_advance);
  COV_RSV: cover property (clock_sel_reserved);
  COV_ERR: cover property (pslverr);
endmodule
`default_nettype wire

/* pscr_tb.sv */
// self-checking testbench for the palette, sprite and clock registers
`timescale 1ns/1ns
`default_nettype none
`include "pscr_consts.vh"
module testbench;
  // ****************************************************************
  // design signals
  // ****************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, pal_wr_advance, spr_wr_advance;
  logic [31:0] prdata;
  logic [7:0] pal_wr_index = 8'h00;
  logic [13:0] spr_wr_index = 14'h0000;
  logic [7:0] pixel_value = 8'h00;
  logic [7:0] lookup_index, spr_disp_byte;
  logic [17:0] lookup_rgb;
  logic [13:0] spr_disp_addr = 14'h0000;
  logic [4:0] clock_source;
  logic clock_sel_reserved, clock_div_two, clock_div_reserved;
  int miscompares = 0;
  int compares = 0;
  logic last_err;
  logic [31:0] rd;
  always #20 pclk = ~pclk;
  pscr_regs i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .pal_wr_index(pal_wr_index),
    .spr_wr_index(spr_wr_index),
    .pal_wr_advance(pal_wr_advance),
    .spr_wr_advance(spr_wr_advance),
    .pixel_value(pixel_value),
    .lookup_index(lookup_index),
    .lookup_rgb(lookup_rgb),
    .spr_disp_addr(spr_disp_addr),
    .spr_disp_byte(spr_disp_byte),
    .clock_source(clock_source),
    .clock_sel_reserved(clock_sel_reserved),
    .clock_div_two(clock_div_two),
    .clock_div_reserved(clock_div_reserved)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a transfer that never gets its answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    wr(`PSCR_IDX_MASK, 8'h5A);
    rdchk(`PSCR_IDX_MASK, 8'h5A);
    wr(`PSCR_IDX_SEQ, 8'hFF);
    rdchk(`PSCR_IDX_SEQ, 8'h07);
    wr(`PSCR_IDX_CLK_LOW, 8'hFF);
    rdchk(`PSCR_IDX_CLK_LOW, 8'h0F);
    wr(`PSCR_IDX_CLK_HIGH, 8'hFF);
    rdchk(`PSCR_IDX_CLK_HIGH, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wr(8'(`PSCR_IDX_RED_HOLD + i), 8'hFC);
      rdchk(8'(`PSCR_IDX_RED_HOLD + i), 8'hFC);
    end
    wr(`PSCR_IDX_SPR_HOLD, 8'hA5);
    rdchk(`PSCR_IDX_SPR_HOLD, 8'hA5);
    wr(`PSCR_IDX_RB_LOW, 8'h10);
    rdchk(`PSCR_IDX_RB_LOW, 8'h11);
    wr(8'h71, 8'hFF);
    check(last_err, 1'b1);
    rdchk(8'h71, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_mask;
    wr(`PSCR_IDX_MASK, 8'h0F);
    pixel_value <= 8'hF3;
    tick(2);
    check(lookup_index, 8'h03);
    wr(`PSCR_IDX_MASK, 8'hF0);
    tick(2);
    check(lookup_index, 8'hF0);
    $display("test mask done");
  endtask
  task automatic t_clock;
    logic [4:0] src;
    for (int c = 0; c < 8; c++) begin
      wr(`PSCR_IDX_CLK_HIGH, {c[2], 7'h00});
      wr(`PSCR_IDX_CLK_LOW, {4'h0, c[1:0], c[1:0]});
      tick(2);
      src = c[2] ? ((c[1:0] == 2'h0) ? 5'h10 : 5'h00) : (5'h01 << c[1:0]);
      check(clock_source, src);
      check(clock_sel_reserved, c[2] && c[1:0] != 2'h0);
      check(clock_div_two, c[1:0] == 2'h1);
      check(clock_div_reserved, c[1]);
    end
    wr(`PSCR_IDX_CLK_HIGH, 8'h00);
    wr(`PSCR_IDX_CLK_LOW, 8'h00);
    tick(2);
    check(clock_source, 5'h01);
    $display("test clock done");
  endtask
  task automatic t_palette;
    wr(`PSCR_IDX_SEQ, 8'h00);
    // monochrome entry: red and blue left at zero by software
    pal_wr_index <= 8'h09;
    wr(`PSCR_IDX_PAL_DATA, 8'h00);
    wr(`PSCR_IDX_PAL_DATA, 8'hA8);
    wr(`PSCR_IDX_PAL_DATA, 8'h00);
    pal_wr_index <= 8'h05;
    wr(`PSCR_IDX_PAL_DATA, 8'hFF);
    @(negedge pclk);
    check(pal_wr_advance, 1'b0);
    wr(`PSCR_IDX_PAL_DATA, 8'h83);
    wr(`PSCR_IDX_PAL_DATA, 8'h41);
    @(negedge pclk);
    check(pal_wr_advance, 1'b1);
    wr(`PSCR_IDX_MASK, 8'h0F);
    pixel_value <= 8'hF5;
    tick(2);
    check(lookup_rgb, {6'h3F, 6'h20, 6'h10});
    @(posedge pclk);
    pixel_value <= 8'hF9;
    tick(2);
    check(lookup_rgb, {6'h00, 6'h2A, 6'h00});
    wr(`PSCR_IDX_RB_LOW, 8'h05);
    rdchk(`PSCR_IDX_RED_HOLD, 8'hFC);
    rdchk(`PSCR_IDX_PAL_DATA, 8'hFC);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h80);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h40);
    wr(`PSCR_IDX_RB_LOW, 8'h05);
    wr(`PSCR_IDX_SEQ, 8'h01);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h80);
    wr(`PSCR_IDX_SEQ, 8'h02);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h40);
    wr(`PSCR_IDX_RB_LOW, 8'h05);
    wr(`PSCR_IDX_SEQ, 8'h04);
    rdchk(`PSCR_IDX_PAL_DATA, 8'hFC);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h40);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h80);
    rdchk(`PSCR_IDX_PAL_DATA, 8'h00);
    rdchk(`PSCR_IDX_SEQ, 8'h04);
    $display("test palette done");
  endtask
  task automatic t_sprite;
    spr_wr_index <= 14'h3FFF;
    wr(`PSCR_IDX_SPR_DATA, 8'h5A);
    spr_wr_index <= 14'h0000;
    wr(`PSCR_IDX_SPR_DATA, 8'h11);
    spr_disp_addr <= 14'h3FFF;
    tick(2);
    check(spr_disp_byte, 8'h5A);
    wr(`PSCR_IDX_RB_HIGH, 8'h3F);
    wr(`PSCR_IDX_RB_LOW, 8'hFF);
    rdchk(`PSCR_IDX_SPR_HOLD, 8'h5A);
    rdchk(`PSCR_IDX_RB_HIGH, 8'h00);
    rdchk(`PSCR_IDX_RB_LOW, 8'h00);
    rdchk(`PSCR_IDX_SPR_DATA, 8'h5A);
    rdchk(`PSCR_IDX_SPR_HOLD, 8'h11);
    rdchk(`PSCR_IDX_RB_LOW, 8'h01);
    // task switch: holding byte is saved and restored, the index is not
    wr(`PSCR_IDX_SPR_HOLD, 8'hA5);
    wr(`PSCR_IDX_SPR_HOLD, 8'h11);
    rdchk(`PSCR_IDX_SPR_DATA, 8'h11);
    rdchk(`PSCR_IDX_RB_LOW, 8'h02);
    $display("test sprite done");
  endtask
  // ****************************************************************
  // sequence, watchdog and verdict
  // ****************************************************************
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_mask;
    t_clock;
    t_palette;
    t_sprite;
    print_verdict;
  end
  // the tests need well under a thousand cycles
  initial begin
    #(40 * 5000);
    miscompares++;
    $display("BAD at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule
bind pscr_regs pscr_regs_sva i_sva (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .prdata(prdata),
  .pal_wr_index(pal_wr_index),
  .spr_wr_index(spr_wr_index),
  .pal_wr_advance(pal_wr_advance),
  .spr_wr_advance(spr_wr_advance),
  .pixel_value(pixel_value),
  .lookup_index(lookup_index),
  .lookup_rgb(lookup_rgb),
  .spr_disp_addr(spr_disp_addr),
  .spr_disp_byte(spr_disp_byte),
  .clock_source(clock_source),
  .clock_sel_reserved(clock_sel_reserved),
  .clock_div_two(clock_div_two),
  .clock_div_reserved(clock_div_reserved)
);
`default_nettype wire
